// >>> design/pdrbo_pkg.sv
package pdrbo_pkg;
    // instruction word layout
    localparam int WORD_W = 10;
    localparam int DATA_W = 4;
    // opcodes of the decoded group
    localparam logic [9:0] OP_CLOCK_RUN_SLEEP = 10'h002;
    localparam logic [9:0] OP_RAM_RETENTION = 10'h008;
    localparam logic [9:0] OP_ROTATE_RIGHT = 10'h01d;
    localparam logic [9:0] OP_POWERDOWN_ENABLE = 10'h02e;
    // bit clear: upper eight bits fixed, low two bits carry the bit index
    localparam logic [7:0] OP_BIT_CLEAR_HI = 8'h13;
    localparam int BIT_IDX_LSB = 0;
    localparam int BIT_IDX_W = 2;
    // reset values
    localparam logic RST_ENABLE_ARMED = 1'b0;
    localparam logic [1:0] RST_POWER_STATE = 2'h0;

    typedef enum logic [1:0] {
        PWR_RUN = 2'b00,
        PWR_CLOCK_RUN = 2'b01,
        PWR_RAM_RETAIN = 2'b10
    } pdrbo_power_e;

    // one instruction presented by the fetch stage
    typedef struct packed {
        logic valid;
        logic [9:0] word;
    } pdrbo_instr_s;

    // write-back results, one machine cycle after the instruction
    typedef struct packed {
        logic accWe;
        logic [3:0] accOut;
        logic carryWe;
        logic carryOut;
        logic memWe;
        logic [3:0] memWdata;
    } pdrbo_result_s;
endpackage

// >>> design/pdrbo_power_down_rotate_bitclear_ops.sv
// Function
// - clock-run sleep opcode right after the enable opcode enters clock-run sleep
// - clock-run sleep opcode without the enable just before acts as no-operation
// - ram retention opcode right after the enable opcode enters ram retention
// - ram retention opcode without the enable just before acts as no-operation
// - rotate right shifts accumulator through carry; old carry to bit 3
// - bit clear zeroes bit j of the addressed memory word, others kept
// - the cleared bit index comes from the instruction word's immediate field
`timescale 1ns/10ps
`default_nettype none
module pdrbo_power_down_rotate_bitclear_ops (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // instruction from fetch, one per machine cycle
    input wire pdrbo_pkg::pdrbo_instr_s instr,
    // core state read at the time of the instruction
    input wire logic [3:0] accIn,
    input wire logic carryIn,
    input wire logic [3:0] memRdata,
    // wake event from the power-mode hardware
    input wire logic wakeUp,
    // write-back to the core
    output pdrbo_pkg::pdrbo_result_s result,
    // power-mode control
    output pdrbo_pkg::pdrbo_power_e powerState,
    output logic enterClockRunSleep,
    output logic enterRamRetention,
    // sequencing
    output logic done,
    output logic skip
);
    logic isClockSleep;
    logic isRamRetain;
    logic isRotate;
    logic isBitClear;
    logic isEnable;
    logic execute;
    logic enableArmed;
    logic [1:0] bitIdx;
    logic [3:0] clearMask;
    pdrbo_pkg::pdrbo_result_s next_result;
    logic armedClockSleep;
    logic armedRamRetain;

    // decode; instructions are only taken while running
    // full-word compares, and an upper-eight-bit compare for bit clear, keep neighbouring opcodes out of this group
    assign execute = instr.valid && (powerState == pdrbo_pkg::PWR_RUN);
    assign isClockSleep = execute && (instr.word == pdrbo_pkg::OP_CLOCK_RUN_SLEEP);
    assign isRamRetain = execute && (instr.word == pdrbo_pkg::OP_RAM_RETENTION);
    assign isRotate = execute && (instr.word == pdrbo_pkg::OP_ROTATE_RIGHT);
    assign isEnable = execute && (instr.word == pdrbo_pkg::OP_POWERDOWN_ENABLE);
    assign isBitClear = execute && (instr.word[9:2] == pdrbo_pkg::OP_BIT_CLEAR_HI);
    // bit index straight from the immediate field, never from a register
    assign bitIdx = instr.word[pdrbo_pkg::BIT_IDX_LSB +: pdrbo_pkg::BIT_IDX_W];
    // one hole at the chosen bit; every other bit of the word passes through
    assign clearMask = ~(4'h1 << bitIdx);

    // an entry opcode only counts when the enable was the last one executed
    assign armedClockSleep = isClockSleep && enableArmed;
    assign armedRamRetain = isRamRetain && enableArmed;

    // enable is armed only by the instruction executed immediately before;
    // any other executed instruction disarms it; idle cycles with no executed instruction keep it armed
    always_ff @(posedge clk) begin
        if (rst) begin
            enableArmed <= pdrbo_pkg::RST_ENABLE_ARMED;
        end else if (execute) begin
            enableArmed <= isEnable;
        end
    end

    // write-back values
    always_comb begin
        next_result = '0;
        if (isRotate) begin
            next_result.accWe = 1'b1;
            next_result.accOut = {carryIn, accIn[3:1]};
            next_result.carryWe = 1'b1;
            next_result.carryOut = accIn[0];
        end
        if (isBitClear) begin
            next_result.memWe = 1'b1;
            next_result.memWdata = memRdata & clearMask;
        end
    end

    // results registered so data outputs come from flip-flops
    always_ff @(posedge clk) begin
        if (rst) begin
            result <= '0;
        end else begin
            result <= next_result;
        end
    end

    // power state; an unarmed entry opcode falls through as a no-operation
    always_ff @(posedge clk) begin
        if (rst) begin
            powerState <= pdrbo_power_e_rst();
            enterClockRunSleep <= 1'b0;
            enterRamRetention <= 1'b0;
        end else begin
            enterClockRunSleep <= armedClockSleep;
            enterRamRetention <= armedRamRetain;
            // entry wins over a wake level seen in the same cycle, so a stale
            // wake request cannot cancel an armed power-down
            if (armedClockSleep) begin
                powerState <= pdrbo_pkg::PWR_CLOCK_RUN;
            end else if (armedRamRetain) begin
                powerState <= pdrbo_pkg::PWR_RAM_RETAIN;
            end else if (wakeUp) begin
                powerState <= pdrbo_pkg::PWR_RUN;
            end
        end
    end

    function automatic pdrbo_pkg::pdrbo_power_e pdrbo_power_e_rst();
        return pdrbo_pkg::pdrbo_power_e'(pdrbo_pkg::RST_POWER_STATE);
    endfunction

    // single cycle completion for every taken instruction, never a skip
    always_ff @(posedge clk) begin
        if (rst) begin
            done <= 1'b0;
        end else begin
            done <= execute;
        end
    end
    // no opcode of this group ever skips the following word
    assign skip = 1'b0;

    // checks run on the core clock and rest while reset is held
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // outcome of both power-down opcodes, armed and unarmed
    chk_sleep_entry: assert property (isClockSleep && enableArmed |=>
        powerState == pdrbo_pkg::PWR_CLOCK_RUN && enterClockRunSleep)
        else $error("armed clock-run sleep did not enter");
    chk_sleep_nop: assert property (isClockSleep && !enableArmed |=>
        powerState == pdrbo_pkg::PWR_RUN && !enterClockRunSleep && !result.accWe)
        else $error("unarmed clock-run sleep was not a no-operation");
    chk_retain_entry: assert property (isRamRetain && enableArmed |=>
        powerState == pdrbo_pkg::PWR_RAM_RETAIN && enterRamRetention)
        else $error("armed ram retention did not enter");
    chk_retain_nop: assert property (isRamRetain && !enableArmed |=>
        powerState == pdrbo_pkg::PWR_RUN && !enterRamRetention)
        else $error("unarmed ram retention was not a no-operation");

    // datapath values one cycle after the opcode is taken
    chk_rotate_value: assert property (isRotate |=>
        result.accOut == {$past(carryIn), $past(accIn[3:1])} && result.carryOut == $past(accIn[0]))
        else $error("rotate right result wrong");
    chk_clear_value: assert property (isBitClear |=> result.memWe &&
        result.memWdata[$past(bitIdx)] == 1'b0 &&
        (result.memWdata | ~$past(clearMask)) == ($past(memRdata) | ~$past(clearMask)))
        else $error("bit clear result wrong");
    chk_clear_index: assert property (isBitClear |=>
        result.memWdata == ($past(memRdata) & ~(4'h1 << $past(instr.word[1:0]))))
        else $error("bit clear index not taken from the immediate");

    // write enables trace back to the one opcode allowed to raise them
    chk_carry_only_rotate: assert property (result.carryWe |-> $past(isRotate))
        else $error("carry written by a non-rotate instruction");
    chk_acc_only_rotate: assert property (result.accWe |-> $past(isRotate))
        else $error("accumulator written by a non-rotate instruction");
    chk_mem_only_clear: assert property (result.memWe |-> $past(isBitClear))
        else $error("memory written by a non-clear instruction");
    chk_single_cycle: assert property (execute |=> done && !skip)
        else $error("instruction did not complete in one cycle");

    // arming window: only the instruction executed just before counts
    chk_arm_follows: assert property (execute |=> enableArmed == $past(isEnable))
        else $error("enable arming did not follow the last executed instruction");
    chk_arm_idle_hold: assert property (!execute |=> enableArmed == $past(enableArmed))
        else $error("enable arming changed without an executed instruction");
    chk_sleep_pulse: assert property (enterClockRunSleep |-> $past(armedClockSleep))
        else $error("clock-run sleep entered without the enable just before");
    chk_retain_pulse: assert property (enterRamRetention |-> $past(armedRamRetain))
        else $error("ram retention entered without the enable just before");
    chk_sleep_pulse_once: assert property (enterClockRunSleep |=> !enterClockRunSleep)
        else $error("clock-run sleep entry pulse lasted more than one cycle");
    chk_retain_pulse_once: assert property (enterRamRetention |=> !enterRamRetention)
        else $error("ram retention entry pulse lasted more than one cycle");

    // a power-down opcode writes nothing back, armed or not
    chk_entry_no_write: assert property ((isClockSleep || isRamRetain) |=>
        done && !result.accWe && !result.carryWe && !result.memWe)
        else $error("power-down opcode wrote back core state");
    chk_enable_no_write: assert property (isEnable |=> done && result == '0)
        else $error("power-down enable opcode wrote back core state");

    // a low-power state holds until a wake and ignores offered opcodes
    chk_sleep_holds: assert property (!wakeUp &&
        powerState == pdrbo_pkg::PWR_CLOCK_RUN |=> powerState == pdrbo_pkg::PWR_CLOCK_RUN)
        else $error("clock-run sleep left without a wake");
    chk_retain_holds: assert property (!wakeUp &&
        powerState == pdrbo_pkg::PWR_RAM_RETAIN |=> powerState == pdrbo_pkg::PWR_RAM_RETAIN)
        else $error("ram retention left without a wake");
    chk_asleep_ignored: assert property (instr.valid &&
        powerState != pdrbo_pkg::PWR_RUN |=> !done && result == '0)
        else $error("instruction acted on while powered down");

    // side effects stay with their own opcode
    chk_rotate_no_mem: assert property (isRotate |=> result.accWe && !result.memWe)
        else $error("rotate right wrote memory or missed the accumulator");
    chk_clear_no_acc: assert property (isBitClear |=> !result.accWe && !result.carryWe)
        else $error("bit clear touched the accumulator or carry");
    chk_clear_one_bit: assert property (isBitClear |-> $onehot(~clearMask))
        else $error("bit clear mask does not select exactly one bit");
    chk_done_only_taken: assert property (done |-> $past(execute))
        else $error("completion flagged without a taken instruction");

    // scenarios worth seeing at least once
    cov_sleep_entry: cover property (isEnable ##1 isClockSleep);
    cov_retain_entry: cover property (isEnable ##1 isRamRetain);
    cov_gap_nop: cover property (isEnable ##1 isRotate ##1 isRamRetain);
    cov_clear_top: cover property (isBitClear && bitIdx == 2'h3);
    cov_wake_return: cover property (powerState != pdrbo_pkg::PWR_RUN && wakeUp);
endmodule // pdrbo_power_down_rotate_bitclear_ops
`default_nettype wire

// >>> testbench/pdrbo_power_down_rotate_bitclear_ops_tb.sv
`timescale 1ns/10ps
`default_nettype none
module pdrbo_power_down_rotate_bitclear_ops_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    pdrbo_pkg::pdrbo_instr_s instr = '0;
    logic [3:0] accIn = 4'h0;
    logic carryIn = 1'b0;
    logic [3:0] memRdata = 4'h0;
    logic wakeUp = 1'b0;
    pdrbo_pkg::pdrbo_result_s result;
    pdrbo_pkg::pdrbo_power_e powerState;
    logic enterClockRunSleep;
    logic enterRamRetention;
    logic done;
    logic skip;
    logic [5:0] st;
    int fails = 0;
    int num_checks = 0;
    int cycles = 0;
    // status word: done, skip, both entry pulses, power state
    assign st = {done, skip, enterClockRunSleep, enterRamRetention, powerState};
    always #2 clk = ~clk;
    pdrbo_power_down_rotate_bitclear_ops pdrbo_power_down_rotate_bitclear_ops_i (.clk(clk),
        .rst(rst), .instr(instr), .accIn(accIn), .carryIn(carryIn), .memRdata(memRdata),
        .wakeUp(wakeUp), .result(result), .powerState(powerState),
        .enterClockRunSleep(enterClockRunSleep), .enterRamRetention(enterRamRetention),
        .done(done), .skip(skip));
    task automatic give_verdict();
        if (fails == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    // one instruction, then an idle cycle; outputs settle one edge after the take
    task automatic run(input logic [9:0] w, input logic [3:0] a, input logic c, input logic [3:0] m);
        @(posedge clk);
        instr <= {1'b1, w};
        accIn <= a;
        carryIn <= c;
        memRdata <= m;
        @(posedge clk);
        instr <= '0;
        #1;
    endtask
    // a wake pulse; the idle level after it keeps later instructions clean
    task automatic wake();
        @(posedge clk);
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        #1;
        chk("woken", 8'h00, st);
    endtask
    task automatic t_rotate();
        for (int i = 0; i < 32; i++) begin
            run(pdrbo_pkg::OP_ROTATE_RIGHT, i[3:0], i[4], 4'h0);
            chk("rot we", 8'h06, {result.accWe, result.carryWe, result.memWe});
            chk("rot acc", {4'h0, i[4], i[3:1]}, result.accOut);
            chk("rot cy", {7'h00, i[0]}, result.carryOut);
            chk("rot st", 8'h20, st);
        end
    endtask
    task automatic t_bitclear();
        // two memory patterns so a wrong index shows on set bits
        for (int i = 0; i < 8; i++) begin
            run({pdrbo_pkg::OP_BIT_CLEAR_HI, i[1:0]}, 4'ha, 1'b1, i[2] ? 4'h5 : 4'hf);
            chk("bc we", 8'h01, {result.accWe, result.carryWe, result.memWe});
            chk("bc data", (i[2] ? 8'h05 : 8'h0f) & ~(8'h01 << i[1:0]), result.memWdata);
            chk("bc st", 8'h20, st);
        end
    endtask
    task automatic t_sleep();
        run(pdrbo_pkg::OP_CLOCK_RUN_SLEEP, 4'h0, 1'b0, 4'h0);
        chk("nop sleep", 8'h20, st);
        run(pdrbo_pkg::OP_POWERDOWN_ENABLE, 4'h0, 1'b0, 4'h0);
        repeat (3) @(posedge clk);
        run(pdrbo_pkg::OP_CLOCK_RUN_SLEEP, 4'h0, 1'b0, 4'h0);
        chk("enter sleep", 8'h29, st);
        run(pdrbo_pkg::OP_ROTATE_RIGHT, 4'h3, 1'b1, 4'h0);
        chk("asleep st", 8'h01, st);
        chk("asleep we", 8'h00, {result.accWe, result.carryWe, result.memWe});
        wake();
    endtask
    task automatic t_retain();
        run(pdrbo_pkg::OP_POWERDOWN_ENABLE, 4'h0, 1'b0, 4'h0);
        run(pdrbo_pkg::OP_ROTATE_RIGHT, 4'h0, 1'b0, 4'h0);
        run(pdrbo_pkg::OP_RAM_RETENTION, 4'h0, 1'b0, 4'h0);
        chk("nop retain", 8'h20, st);
        run(pdrbo_pkg::OP_POWERDOWN_ENABLE, 4'h0, 1'b0, 4'h0);
        run(pdrbo_pkg::OP_RAM_RETENTION, 4'h0, 1'b0, 4'h0);
        chk("enter retain", 8'h26, st);
        wake();
    endtask
    // hang guard: whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("reset st", 8'h00, st);
        t_sleep();
        t_retain();
        t_rotate();
        t_bitclear();
        give_verdict();
    end
endmodule // pdrbo_power_down_rotate_bitclear_ops_tb
`default_nettype wire
